// ===== efs_delay.sv
// loadable down counter used for fault timing
`default_nettype none
module efs_delay (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   efs_delay_if.timer dly
);
   logic [efs_pkg::CNT_W-1:0] cnt;
   logic [efs_pkg::CNT_W-1:0] next_cnt;

   // load wins over counting so a restart always gives the full interval
   always_comb begin
      next_cnt = cnt;
      if (dly.load) begin
         next_cnt = dly.value;
      end else if (cnt != efs_pkg::CNT_ZERO) begin
         next_cnt = cnt - efs_pkg::CNT_ONE;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt <= efs_pkg::CNT_ZERO;
      end else begin
         cnt <= next_cnt;
      end
   end

   assign dly.done = (cnt == efs_pkg::CNT_ONE) && !dly.load;
endmodule : efs_delay
`default_nettype wire

// ===== efs_delay_if.sv
// interface between the sequencer and its delay counter
`default_nettype none
interface efs_delay_if;
   logic load;
   logic [efs_pkg::CNT_W-1:0] value;
   logic done;
   modport ctrl (output load, output value, input done);
   modport timer (input load, input value, output done);
endinterface : efs_delay_if
`default_nettype wire

// ===== efs_fault_sequencer.sv
// top of the efuse fault sequencer: protection, recovery and indicators
`default_nettype none
module efs_fault_sequencer #(
   parameter bit AUTO_RETRY = 1'b1,
   parameter bit REVERSE_BLOCK = 1'b0,
   parameter logic [efs_pkg::CNT_W-1:0] FT_DEGLITCH = efs_pkg::CNT_W'(efs_pkg::FT_DEGLITCH_CYC),
   parameter logic [efs_pkg::CNT_W-1:0] BLANK = efs_pkg::CNT_W'(efs_pkg::BLANK_CYC),
   parameter logic [efs_pkg::CNT_W-1:0] PGA = efs_pkg::CNT_W'(efs_pkg::PGA_CYC),
   parameter logic [efs_pkg::CNT_W-1:0] PGD = efs_pkg::CNT_W'(efs_pkg::PGD_CYC),
   parameter logic [efs_pkg::CNT_W-1:0] RETRY = efs_pkg::CNT_W'(efs_pkg::RETRY_CYC)
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // comparator events, asynchronous
   input wire logic scalable_trip_in,
   input wire logic fixed_trip_in,
   input wire logic overcurrent_in,
   input wire logic over_temp_in,
   input wire logic temp_below_hys_in,
   input wire logic enable_ok_in,
   input wire logic enable_shutdown_in,
   input wire logic supply_undervoltage_in,
   input wire logic overvoltage_in,
   input wire logic monitor_open_in,
   input wire logic monitor_short_in,
   input wire logic gate_full_in,
   // power stage controls
   output logic fet_on,
   output logic current_limit_mode,
   output logic output_discharge,
   output logic slew_control_pin_o,
   output logic slew_control_pin_oe,
   // indicators
   output logic fault_out_n,
   output logic power_good_out_o,
   output logic power_good_out_oe
);
   // **********************************************************
   // input synchronisers
   // **********************************************************
   localparam int NSYNC = 12;
   logic [NSYNC-1:0] async_in;
   logic [NSYNC-1:0] sync_a;
   logic [NSYNC-1:0] sync_b;
   assign async_in = {gate_full_in, monitor_short_in, monitor_open_in, overvoltage_in,
                      supply_undervoltage_in, enable_shutdown_in, enable_ok_in, temp_below_hys_in,
                      over_temp_in, overcurrent_in, fixed_trip_in, scalable_trip_in};

   // two stages per input; only the second stage is read by logic
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge clk) begin
            if (rst) begin
               sync_a[gi] <= 1'b0;
               sync_b[gi] <= 1'b0;
            end else begin
               sync_a[gi] <= async_in[gi];
               sync_b[gi] <= sync_a[gi];
            end
         end
      end
   endgenerate

   logic s_sc, s_ft, s_oc, s_ot, s_cool, s_en, s_sd, s_uvp, s_ov, s_mopen, s_mshort, s_gate;
   assign {s_gate, s_mshort, s_mopen, s_ov, s_uvp, s_sd, s_en, s_cool, s_ot, s_oc, s_ft, s_sc} = sync_b;

   // severe overcurrent from either trip comparator
   logic severe;
   assign severe = s_sc || s_ft;
   // unlatched lockouts: input undervoltage, enable below lockout, overvoltage
   logic lockout;
   assign lockout = s_uvp || !s_en || s_ov;

   // **********************************************************
   // delay counters
   // **********************************************************
   efs_delay_if seq_dly ();
   efs_delay_if blank_dly ();
   efs_delay_if pg_dly ();
   efs_delay u_seq_dly (.clk(clk), .rst(rst), .dly(seq_dly));
   efs_delay u_blank_dly (.clk(clk), .rst(rst), .dly(blank_dly));
   efs_delay u_pg_dly (.clk(clk), .rst(rst), .dly(pg_dly));

   // **********************************************************
   // blanking timer: overcurrent and open monitor pin
   // **********************************************************
   logic blank_run;
   logic next_blank_run;
   logic blank_cond;
   logic on_state;
   assign blank_cond = on_state && (s_oc || s_mopen) && !severe;

   // stays armed while the condition holds; a dropout resets it to full
   always_comb begin
      next_blank_run = blank_run;
      blank_dly.load = 1'b0;
      blank_dly.value = BLANK;
      if (!blank_cond) begin
         next_blank_run = 1'b0;
      end else if (!blank_run || blank_dly.done) begin
         next_blank_run = !blank_dly.done;
         blank_dly.load = !blank_run;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         blank_run <= 1'b0;
      end else begin
         blank_run <= next_blank_run;
      end
   end

   logic blank_expired;
   assign blank_expired = blank_run && blank_dly.done;

   // **********************************************************
   // main sequencer
   // **********************************************************
   efs_pkg::efs_state_e state;
   efs_pkg::efs_state_e next_state;
   logic flt_low;
   logic next_flt_low;
   logic latched;
   logic next_latched;
   assign on_state = (state == efs_pkg::EFS_ON) || (state == efs_pkg::EFS_ILIMIT);

   always_comb begin
      next_state = state;
      next_flt_low = flt_low;
      next_latched = latched;
      seq_dly.load = 1'b0;
      seq_dly.value = FT_DEGLITCH;
      if (latched && s_sd) begin
         // clearing a latched fault releases the output and drops the retry timer
         next_state = efs_pkg::EFS_OFF;
         next_flt_low = 1'b0;
         next_latched = 1'b0;
         seq_dly.load = 1'b1;
         seq_dly.value = efs_pkg::CNT_ZERO;
      end else if (latched) begin
         // only a real shutdown level or retry expiry clears; slight undervoltage is ignored
         case (state)
            efs_pkg::EFS_COOL: begin
               if (s_cool && !s_ot) begin
                  if (AUTO_RETRY) begin
                     next_state = efs_pkg::EFS_RETRY;
                     seq_dly.load = 1'b1;
                     seq_dly.value = RETRY;
                  end else begin
                     next_state = efs_pkg::EFS_LATCHED;
                  end
               end
            end
            efs_pkg::EFS_RETRY: begin
               if (seq_dly.done) begin
                  next_state = efs_pkg::EFS_OFF;
                  next_flt_low = 1'b0;
                  next_latched = 1'b0;
               end
            end
            efs_pkg::EFS_LATCHED: begin
               if (AUTO_RETRY) begin
                  next_state = efs_pkg::EFS_RETRY;
                  seq_dly.load = 1'b1;
                  seq_dly.value = RETRY;
               end
            end
            default: next_state = efs_pkg::EFS_LATCHED;
         endcase
      end else if (s_ot) begin
         next_state = efs_pkg::EFS_COOL;
         next_flt_low = 1'b1;
         next_latched = 1'b1;
      end else if (s_mshort && state != efs_pkg::EFS_OFF) begin
         next_state = efs_pkg::EFS_LATCHED;
         next_flt_low = 1'b1;
         next_latched = 1'b1;
      end else if (lockout) begin
         next_state = efs_pkg::EFS_OFF;
         next_flt_low = 1'b0;
      end else begin
         case (state)
            efs_pkg::EFS_OFF: begin
               // after an open-pin fault, an open monitor pin keeps the part off until the pin recovers
               if (!(flt_low && s_mopen)) begin
                  next_flt_low = 1'b0;
                  next_state = efs_pkg::EFS_INRUSH;
               end
            end
            efs_pkg::EFS_INRUSH: begin
               if (severe) begin
                  next_state = efs_pkg::EFS_TRIP_WAIT;
                  seq_dly.load = 1'b1;
               end else if (s_gate) begin
                  next_state = efs_pkg::EFS_ON;
               end
            end
            efs_pkg::EFS_ON, efs_pkg::EFS_ILIMIT: begin
               if (severe) begin
                  next_state = efs_pkg::EFS_TRIP_WAIT;
                  seq_dly.load = 1'b1;
               end else if (blank_expired && s_mopen) begin
                  next_state = efs_pkg::EFS_OFF;
                  next_flt_low = 1'b1;
               end else if (blank_expired) begin
                  next_state = efs_pkg::EFS_LATCHED;
                  next_latched = 1'b1;
               end
            end
            efs_pkg::EFS_TRIP_WAIT: begin
               if (seq_dly.done) begin
                  next_state = efs_pkg::EFS_ILIMIT;
               end
            end
            default: next_state = efs_pkg::EFS_OFF;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= efs_pkg::EFS_OFF;
         flt_low <= 1'b0;
         latched <= 1'b0;
      end else begin
         state <= next_state;
         flt_low <= next_flt_low;
         latched <= next_latched;
      end
   end

   // **********************************************************
   // power stage outputs
   // **********************************************************
   logic next_fet_on;
   logic next_ilim;
   logic next_qod;
   logic next_blk;

   // in current limit a persistent short trips again to EFS_TRIP_WAIT, turning the FET off for another deglitch
   always_comb begin
      next_fet_on = (next_state == efs_pkg::EFS_INRUSH) || (next_state == efs_pkg::EFS_ON) ||
                    (next_state == efs_pkg::EFS_ILIMIT);
      next_ilim = (next_state == efs_pkg::EFS_ILIMIT);
      next_qod = !s_en && !s_ot;
      next_blk = REVERSE_BLOCK && (next_state == efs_pkg::EFS_ON);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         fet_on <= 1'b0;
         current_limit_mode <= 1'b0;
         output_discharge <= 1'b0;
         slew_control_pin_o <= 1'b0;
      end else begin
         fet_on <= next_fet_on;
         current_limit_mode <= next_ilim;
         output_discharge <= next_qod;
         slew_control_pin_o <= next_blk;
      end
   end

   assign slew_control_pin_oe = REVERSE_BLOCK;
   assign fault_out_n = !flt_low;

   // **********************************************************
   // power-good deglitch
   // **********************************************************
   // the deassert path starts after the FET is off, so overload cases pick
   // up the blanking interval naturally before the deglitch
   logic pg;
   logic next_pg;
   logic pg_pend;
   logic next_pg_pend;
   logic pg_want;
   assign pg_want = (state == efs_pkg::EFS_ON) && fet_on;

   always_comb begin
      next_pg = pg;
      next_pg_pend = pg_pend;
      pg_dly.load = 1'b0;
      pg_dly.value = pg_want ? PGA : PGD;
      if (pg_want == pg) begin
         next_pg_pend = 1'b0;
      end else if (!pg_pend) begin
         next_pg_pend = 1'b1;
         pg_dly.load = 1'b1;
      end else if (pg_dly.done) begin
         next_pg = pg_want;
         next_pg_pend = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pg <= 1'b0;
         pg_pend <= 1'b0;
      end else begin
         pg <= next_pg;
         pg_pend <= next_pg_pend;
      end
   end

   // open drain: enable pulls the pin low when not good
   assign power_good_out_o = 1'b0;
   assign power_good_out_oe = !pg;

   // **********************************************************
   // checks
   // **********************************************************
   property p_trip_off;
      @(posedge clk) disable iff (rst) (on_state && severe && !latched && !s_ot && !lockout && !s_mshort)
         |=> ##1 !fet_on;
   endproperty
   a_trip_off: assert property (p_trip_off) else $error("fet not off after trip");

   property p_trip_limit;
      @(posedge clk) disable iff (rst) $rose(state == efs_pkg::EFS_ILIMIT) |=> current_limit_mode;
   endproperty
   a_trip_limit: assert property (p_trip_limit) else $error("no current limit after trip");

   property p_ot_off;
      @(posedge clk) disable iff (rst) s_ot |=> (!fet_on && !output_discharge);
   endproperty
   a_ot_off: assert property (p_ot_off) else $error("fet or discharge on in overtemperature");

   property p_ot_flt;
      @(posedge clk) disable iff (rst) (s_ot && !latched) |=> !fault_out_n;
   endproperty
   a_ot_flt: assert property (p_ot_flt) else $error("fault not low after overtemperature");

   property p_clear;
      @(posedge clk) disable iff (rst) (latched && s_sd) |=> fault_out_n;
   endproperty
   a_clear: assert property (p_clear) else $error("latched fault not cleared");

   property p_pg_steady;
      // the deglitch starts one cycle after leaving steady state
      @(posedge clk) disable iff (rst) !power_good_out_oe |->
         (state == efs_pkg::EFS_ON || pg_pend || $past(state == efs_pkg::EFS_ON));
   endproperty
   a_pg_steady: assert property (p_pg_steady) else $error("power good outside steady state");

   sequence s_fet_drop;
      $fell(fet_on) ##1 !fet_on;
   endsequence
   property p_pg_drop;
      @(posedge clk) disable iff (rst) (s_fet_drop and ##0 !power_good_out_oe) |-> ##[1:300] power_good_out_oe;
   endproperty
   a_pg_drop: assert property (p_pg_drop) else $error("power good held after fet off");

   property p_qod;
      @(posedge clk) disable iff (rst) (!s_en && !s_ot) |=> output_discharge;
   endproperty
   a_qod: assert property (p_qod) else $error("discharge off with enable low");

   property p_blk;
      @(posedge clk) disable iff (rst) slew_control_pin_o |-> fet_on;
   endproperty
   a_blk: assert property (p_blk) else $error("blocking gate high with fet off");
endmodule : efs_fault_sequencer
`default_nettype wire

// ===== efs_fault_sequencer_bench.sv
// self-checking bench for the efuse fault sequencer
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module efs_fault_sequencer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   // ************************************
   // setup
   // ************************************
   // shortened counts keep the run brief; sync adds up to LAT cycles
   localparam logic [efs_pkg::CNT_W-1:0] FT = 16'h0028;
   localparam logic [efs_pkg::CNT_W-1:0] BLANK = 16'h0010;
   localparam logic [efs_pkg::CNT_W-1:0] PGA = 16'h000a;
   localparam logic [efs_pkg::CNT_W-1:0] PGD = 16'h0008;
   localparam logic [efs_pkg::CNT_W-1:0] RETRY = 16'h0010;
   localparam int LAT = 8;
   localparam int S_FET = 0, S_FAULT = 1, S_PG = 2, S_LIM = 3, S_DIS = 4, S_SLEW = 5;
   int error_cnt = 0;
   int tests_run = 0;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic scalable_trip_in = 1'b0, fixed_trip_in = 1'b0, overcurrent_in = 1'b0;
   logic over_temp_in = 1'b0, temp_below_hys_in = 1'b1, supply_undervoltage_in = 1'b0;
   logic overvoltage_in = 1'b0, monitor_open_in = 1'b0, monitor_short_in = 1'b0;
   logic gate_full_in = 1'b0;
   logic [1:0] en_level = 2'h0;
   logic enable_ok_in, enable_shutdown_in, pg_seen, fault_seen;
   logic fet_on, current_limit_mode, output_discharge, slew_control_pin_o, slew_control_pin_oe;
   logic fault_out_n, power_good_out_o, power_good_out_oe;

   always #25 clk = ~clk;

   efs_fault_sequencer #(.AUTO_RETRY(1'b1), .REVERSE_BLOCK(1'b1), .FT_DEGLITCH(FT), .BLANK(BLANK),
      .PGA(PGA), .PGD(PGD), .RETRY(RETRY)) efs_fault_sequencer_inst (
      .clk(clk), .rst(rst), .scalable_trip_in(scalable_trip_in), .fixed_trip_in(fixed_trip_in),
      .overcurrent_in(overcurrent_in), .over_temp_in(over_temp_in), .temp_below_hys_in(temp_below_hys_in),
      .enable_ok_in(enable_ok_in), .enable_shutdown_in(enable_shutdown_in),
      .supply_undervoltage_in(supply_undervoltage_in), .overvoltage_in(overvoltage_in),
      .monitor_open_in(monitor_open_in), .monitor_short_in(monitor_short_in), .gate_full_in(gate_full_in),
      .fet_on(fet_on), .current_limit_mode(current_limit_mode), .output_discharge(output_discharge),
      .slew_control_pin_o(slew_control_pin_o), .slew_control_pin_oe(slew_control_pin_oe),
      .fault_out_n(fault_out_n), .power_good_out_o(power_good_out_o), .power_good_out_oe(power_good_out_oe));

   efs_host_model efs_host_model_inst (.clk(clk), .en_level(en_level), .power_good_out_o(power_good_out_o),
      .power_good_out_oe(power_good_out_oe), .fault_out_n(fault_out_n), .enable_ok_in(enable_ok_in),
      .enable_shutdown_in(enable_shutdown_in), .pg_seen(pg_seen), .fault_seen(fault_seen));

   // ************************************
   // helpers
   // ************************************
   function automatic logic pick(input int sel);
      case (sel)
         S_FET: return fet_on;
         S_FAULT: return fault_seen;
         S_PG: return pg_seen;
         S_LIM: return current_limit_mode;
         S_DIS: return output_discharge;
         default: return slew_control_pin_o;
      endcase
   endfunction
   // sample 1 ns after the edge so the edge's updates have landed
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // waits a bounded time for an output level, then judges it
   task automatic reach(input int sel, input logic val, input int lim);
      int n;
      n = 0;
      while (pick(sel) !== val && n < lim) begin
         cyc(1);
         n++;
      end
      `CHK(pick(sel), val)
   endtask
   // the level must not move for n cycles
   task automatic hold(input int sel, input logic val, input int n);
      int i;
      for (i = 0; i < n && pick(sel) === val; i++) begin
         cyc(1);
      end
      `CHK(pick(sel), val)
   endtask
   task automatic restart();
      @(posedge clk);
      en_level <= 2'h0;
      reach(S_DIS, 1'b1, LAT);
      @(posedge clk);
      en_level <= 2'h2;
      reach(S_FET, 1'b1, LAT);
      reach(S_PG, 1'b1, int'(PGA) + 2 * LAT);
   endtask
   // ************************************
   // scenarios
   // ************************************
   task automatic t_startup();
      @(posedge clk);
      en_level <= 2'h2;
      reach(S_FET, 1'b1, LAT);
      hold(S_PG, 1'b0, 4);
      @(posedge clk);
      gate_full_in <= 1'b1;
      hold(S_PG, 1'b0, int'(PGA));
      reach(S_PG, 1'b1, LAT);
      reach(S_SLEW, 1'b1, LAT);
      hold(S_FAULT, 1'b1, 1);
      `CHK(slew_control_pin_oe, 1'b1)
      `CHK(power_good_out_o, 1'b0)
      $display("startup test done");
   endtask
   task automatic t_trip(input int which);
      restart();
      @(posedge clk);
      if (which == 0) scalable_trip_in <= 1'b1;
      else fixed_trip_in <= 1'b1;
      reach(S_FET, 1'b0, LAT);
      reach(S_SLEW, 1'b0, 2);
      @(posedge clk);
      scalable_trip_in <= 1'b0;
      fixed_trip_in <= 1'b0;
      hold(S_PG, 1'b1, int'(PGD) - 3);
      reach(S_PG, 1'b0, LAT);
      hold(S_FET, 1'b0, 4);
      reach(S_FET, 1'b1, int'(FT) + LAT);
      reach(S_LIM, 1'b1, 2);
      hold(S_FAULT, 1'b1, 4);
      $display("fast trip test done");
   endtask
   task automatic t_thermal();
      restart();
      @(posedge clk);
      over_temp_in <= 1'b1;
      temp_below_hys_in <= 1'b0;
      reach(S_FET, 1'b0, LAT);
      reach(S_FAULT, 1'b0, 2);
      reach(S_PG, 1'b0, int'(PGD) + LAT);
      @(posedge clk);
      over_temp_in <= 1'b0;
      hold(S_FET, 1'b0, int'(RETRY) + LAT);
      @(posedge clk);
      temp_below_hys_in <= 1'b1;
      hold(S_FET, 1'b0, int'(RETRY) - 2);
      reach(S_FAULT, 1'b1, 3 * LAT);
      reach(S_FET, 1'b1, LAT);
      $display("thermal test done");
   endtask
   task automatic t_discharge();
      @(posedge clk);
      en_level <= 2'h0;
      reach(S_DIS, 1'b1, LAT);
      @(posedge clk);
      over_temp_in <= 1'b1;
      reach(S_DIS, 1'b0, LAT);
      @(posedge clk);
      over_temp_in <= 1'b0;
      reach(S_DIS, 1'b1, LAT);
      $display("discharge test done");
   endtask
   task automatic t_lockout(input int which);
      restart();
      @(posedge clk);
      if (which == 0) overvoltage_in <= 1'b1;
      else supply_undervoltage_in <= 1'b1;
      reach(S_FET, 1'b0, LAT);
      hold(S_FAULT, 1'b1, LAT);
      @(posedge clk);
      overvoltage_in <= 1'b0;
      supply_undervoltage_in <= 1'b0;
      reach(S_FET, 1'b1, 2 * LAT);
      $display("lockout test done");
   endtask
   task automatic t_blank(input int which);
      restart();
      // a short overload, a gap, then an overload or an open monitor pin: the timer must start from full each time
      @(posedge clk);
      overcurrent_in <= 1'b1;
      cyc(int'(BLANK) - 6);
      @(posedge clk);
      overcurrent_in <= 1'b0;
      cyc(4);
      @(posedge clk);
      if (which == 0) overcurrent_in <= 1'b1;
      else monitor_open_in <= 1'b1;
      hold(S_FET, 1'b1, int'(BLANK));
      reach(S_FET, 1'b0, LAT);
      reach(S_FAULT, (which == 0) ? 1'b1 : 1'b0, LAT);
      reach(S_PG, 1'b0, int'(PGD) + LAT);
      @(posedge clk);
      overcurrent_in <= 1'b0;
      monitor_open_in <= 1'b0;
      $display("blanking test done");
   endtask
   task automatic t_mon_short();
      restart();
      @(posedge clk);
      monitor_short_in <= 1'b1;
      reach(S_FAULT, 1'b0, int'(BLANK) + LAT);
      reach(S_FET, 1'b0, 1);
      @(posedge clk);
      monitor_short_in <= 1'b0;
      en_level <= 2'h1;
      hold(S_FAULT, 1'b0, 4);
      @(posedge clk);
      en_level <= 2'h0;
      reach(S_FAULT, 1'b1, LAT);
      $display("monitor short test done");
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ************************************
   // sequence and watchdog
   // ************************************
   // the whole run needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      $display("watchdog expired");
      conclude();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_startup();
      t_trip(0);
      t_trip(1);
      t_thermal();
      t_discharge();
      t_lockout(0);
      t_lockout(1);
      t_blank(0);
      t_blank(1);
      t_mon_short();
      conclude();
   end
endmodule // efs_fault_sequencer_bench
`default_nettype wire

// ===== efs_host_model.sv
// host-side model: drives the enable pin and senses the indicator pins
`default_nettype none
module efs_host_model (
   // clock
   input wire logic clk,
   // bench request: 2 enabled, 1 just under lockout, 0 below shutdown
   input wire logic [1:0] en_level,
   // indicator pins of the device
   input wire logic power_good_out_o,
   input wire logic power_good_out_oe,
   input wire logic fault_out_n,
   // enable comparators and sensed levels
   output logic enable_ok_in,
   output logic enable_shutdown_in,
   output logic pg_seen,
   output logic fault_seen
);
   timeunit 1ns;
   timeprecision 1ns;
   // the gpio moves only just after an edge, never between edges
   initial begin
      enable_ok_in = 1'b0;
      enable_shutdown_in = 1'b1;
   end
   always @(posedge clk) begin
      enable_ok_in <= (en_level == 2'h2);
      enable_shutdown_in <= (en_level == 2'h0);
   end
   // open drain with a pull-up: a released pin reads high
   assign pg_seen = power_good_out_oe ? power_good_out_o : 1'b1;
   assign fault_seen = fault_out_n;
endmodule // efs_host_model
`default_nettype wire

// ===== efs_pkg.sv
// package of constants and types for the efuse fault sequencer
`default_nettype none
package efs_pkg;
   // **********************************************************
   // timing (20 MHz clock, 50 ns period)
   // **********************************************************
   localparam int CLK_PERIOD_NS = 50;
   localparam int FT_DEGLITCH_NS = 30000;
   localparam int FT_DEGLITCH_CYC = (FT_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BLANK_CYC = 4000;
   localparam int PGA_CYC = 200;
   localparam int PGD_CYC = 20;
   localparam int RETRY_CYC = 4000;
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

   // **********************************************************
   // sequencer states
   // **********************************************************
   typedef enum logic [2:0] {
      EFS_OFF = 3'b000,
      EFS_INRUSH = 3'b001,
      EFS_ON = 3'b010,
      EFS_TRIP_WAIT = 3'b011,
      EFS_ILIMIT = 3'b100,
      EFS_LATCHED = 3'b101,
      EFS_COOL = 3'b110,
      EFS_RETRY = 3'b111
   } efs_state_e;
endpackage : efs_pkg
`default_nettype wire
